// [tdf_pkg.sv]
// tdf_pkg: constants and carrier types for the trace data view formatter
// assumes: core transfer fields arrive on ref_clk, registers over AXI4-Lite
package tdf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_COUNT   = 8'h08;
  localparam int         CTRL_GEN2   = 0;
  localparam int         CTRL_DADDR  = 1;
  localparam int         CTRL_ENABLE = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // transfer sizes and instruction classes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TDF_SZ_BYTE = 2'h0,
    TDF_SZ_HALF = 2'h1,
    TDF_SZ_WORD = 2'h2,
    TDF_SZ_DBL  = 2'h3
  } tdf_size_t;

  typedef enum logic [4:0] {
    TDF_OP_SINGLE   = 5'h00,
    TDF_OP_COPROC   = 5'h01,
    TDF_OP_MULTI    = 5'h02,
    TDF_OP_DUAL     = 5'h03,
    TDF_OP_EXCL_DBL = 5'h04,
    TDF_OP_CP_PAIR  = 5'h05,
    TDF_OP_PUSHPOP  = 5'h06,
    TDF_OP_RFE_SRS  = 5'h07,
    TDF_OP_SWAP_W   = 5'h08,
    TDF_OP_SWAP_B   = 5'h09,
    TDF_OP_V_MULTI  = 5'h0A,
    TDF_OP_V_PUSHPOP = 5'h0B,
    TDF_OP_V_DBL    = 5'h0C,
    TDF_OP_V_ELEM   = 5'h0D,
    TDF_OP_V_MOV2   = 5'h0E,
    TDF_OP_V_SINGLE = 5'h0F
  } tdf_op_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] req_addr;
    logic [31:0] mem_addr;
    logic [63:0] mem_data;
    tdf_size_t   size;
    logic        unaligned_ctrl;
    logic        word_big_ctrl;
    logic        cond_pass;
    logic [3:0]  xfer_count;
    tdf_op_t     op;
  } tdf_xfer_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [63:0] data;
    tdf_size_t   size;
    logic        byte_big;
    logic        multi;
  } tdf_trace_t;
endpackage

// [tdf_formatter.sv]
// tdf_formatter: picks traced address and byte order of each transfer
// assumes: core drives xfer fields synchronous to ref_clk, one per valid
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tdf_formatter (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // core transfer
  input  wire logic                 xfer_valid,
  input  wire tdf_pkg::tdf_xfer_t   xfer,
  input  wire logic                 current_program_status_word_e,
  // trace output
  output logic                      trace_valid,
  output tdf_pkg::tdf_trace_t       trace,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  input  wire logic [7:0]           s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready
);
  // ---------------------------------------------------------------
  // byte swap helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] swap_word(input logic [31:0] w);
    swap_word = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  function automatic logic [15:0] swap_half(input logic [15:0] h);
    swap_half = {h[7:0], h[15:8]};
  endfunction

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [2:0]  ctrl_q, ctrl_d;
  logic        last_big_q, last_big_d;
  logic        last_multi_q, last_multi_d;
  logic [31:0] count_q, count_d;
  logic        aw_got_q, aw_got_d;
  logic        w_got_q, w_got_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;

  // ---------------------------------------------------------------
  // trace state
  // ---------------------------------------------------------------
  logic                trace_valid_q, trace_valid_d;
  tdf_pkg::tdf_trace_t trace_q, trace_d;
  logic                big_mode;
  logic                is_multi_class;
  logic [63:0]         view_data;

  assign trace_valid = trace_valid_q;
  assign trace       = trace_q;

  // ---------------------------------------------------------------
  // instruction classification
  // ---------------------------------------------------------------
  always_comb begin
    case (xfer.op)
      tdf_pkg::TDF_OP_COPROC,
      tdf_pkg::TDF_OP_MULTI,
      tdf_pkg::TDF_OP_DUAL,
      tdf_pkg::TDF_OP_EXCL_DBL,
      tdf_pkg::TDF_OP_CP_PAIR,
      tdf_pkg::TDF_OP_PUSHPOP,
      tdf_pkg::TDF_OP_RFE_SRS,
      tdf_pkg::TDF_OP_SWAP_W,
      tdf_pkg::TDF_OP_SWAP_B:   is_multi_class = 1'b1;
      tdf_pkg::TDF_OP_V_MULTI,
      tdf_pkg::TDF_OP_V_PUSHPOP,
      tdf_pkg::TDF_OP_V_DBL,
      tdf_pkg::TDF_OP_V_ELEM,
      tdf_pkg::TDF_OP_V_MOV2:   is_multi_class = 1'b1;
      default:                  is_multi_class = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // data view selection
  // ---------------------------------------------------------------
  // memory data arrives in memory byte order, zero extended, low lanes
  always_comb begin
    big_mode  = current_program_status_word_e | xfer.word_big_ctrl;
    view_data = xfer.mem_data;
    // lane mapping decided only by size, control, status
    if (ctrl_q[tdf_pkg::CTRL_GEN2] && current_program_status_word_e) begin
      case (xfer.size)
        tdf_pkg::TDF_SZ_HALF:
          view_data = {48'h0, swap_half(xfer.mem_data[15:0])};
        tdf_pkg::TDF_SZ_WORD:
          view_data = {32'h0, swap_word(xfer.mem_data[31:0])};
        tdf_pkg::TDF_SZ_DBL:
          // swap within each word, words stay in memory order
          view_data = {swap_word(xfer.mem_data[63:32]),
                       swap_word(xfer.mem_data[31:0])};
        default:
          view_data = xfer.mem_data;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // trace output path
  // ---------------------------------------------------------------
  always_comb begin
    trace_valid_d = xfer_valid && ctrl_q[tdf_pkg::CTRL_ENABLE];
    trace_d       = trace_q;
    last_big_d    = last_big_q;
    last_multi_d  = last_multi_q;
    count_d       = count_q;
    if (trace_valid_d) begin
      trace_d.addr = xfer.req_addr;
      trace_d.data = view_data;
      trace_d.size = xfer.size;
      // unaligned and word-invariant bits are not carried
      trace_d.byte_big = ctrl_q[tdf_pkg::CTRL_DADDR]
                         & current_program_status_word_e;
      trace_d.multi = xfer.cond_pass && (xfer.xfer_count > 4'h1)
                      && is_multi_class;
      last_big_d   = big_mode;
      last_multi_d = trace_d.multi;
      if (trace_d.multi) begin
        count_d = count_q + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  assign s_awready = !aw_got_q && !bvalid_q;
  assign s_wready  = !w_got_q && !bvalid_q;
  assign s_bvalid  = bvalid_q;
  assign s_bresp   = bresp_q;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    ctrl_d   = ctrl_q;
    if (s_awvalid && s_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_wdata;
      wstrb_d = s_wstrb;
    end
    if (aw_got_q && w_got_q) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = tdf_pkg::RESP_OKAY;
      case (awaddr_q[7:2])
        tdf_pkg::OFF_CTRL[7:2]: begin
          if (wstrb_q[0]) begin
            ctrl_d = wdata_q[2:0];
          end
        end
        tdf_pkg::OFF_STATUS[7:2],
        tdf_pkg::OFF_COUNT[7:2]: bresp_d = tdf_pkg::RESP_OKAY;
        default: bresp_d = tdf_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  assign s_arready = !rvalid_q;
  assign s_rvalid  = rvalid_q;
  assign s_rdata   = rdata_q;
  assign s_rresp   = rresp_q;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_arvalid && s_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = tdf_pkg::RESP_OKAY;
      case (s_araddr[7:2])
        tdf_pkg::OFF_CTRL[7:2]:   rdata_d = {29'h0, ctrl_q};
        tdf_pkg::OFF_STATUS[7:2]: rdata_d = {30'h0, last_multi_q,
                                             last_big_q};
        tdf_pkg::OFF_COUNT[7:2]:  rdata_d = count_q;
        default: begin
          rdata_d = 32'h0;
          rresp_d = tdf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl_q        <= tdf_pkg::CTRL_RESET;
      last_big_q    <= 1'b0;
      last_multi_q  <= 1'b0;
      count_q       <= 32'h0;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= 8'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      bvalid_q      <= 1'b0;
      bresp_q       <= 2'h0;
      rvalid_q      <= 1'b0;
      rdata_q       <= 32'h0;
      rresp_q       <= 2'h0;
      trace_valid_q <= 1'b0;
      trace_q       <= '0;
    end else begin
      ctrl_q        <= ctrl_d;
      last_big_q    <= last_big_d;
      last_multi_q  <= last_multi_d;
      count_q       <= count_d;
      aw_got_q      <= aw_got_d;
      w_got_q       <= w_got_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      bvalid_q      <= bvalid_d;
      bresp_q       <= bresp_d;
      rvalid_q      <= rvalid_d;
      rdata_q       <= rdata_d;
      rresp_q       <= rresp_d;
      trace_valid_q <= trace_valid_d;
      trace_q       <= trace_d;
    end
  end
endmodule
`default_nettype wire

// [tdf_formatter_sva.sv]
// tdf_formatter_sva: port checker for the trace formatter
// assumes: bound into tdf_formatter, single ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module tdf_formatter_sva (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                reset_n,
  // core side
  input wire logic                xfer_valid,
  input wire tdf_pkg::tdf_xfer_t  xfer,
  input wire logic                current_program_status_word_e,
  // trace side
  input wire logic                trace_valid,
  input wire tdf_pkg::tdf_trace_t trace
);
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic        m_ok;
  logic [31:0] lo_sw;
  assign m_ok  = xfer.cond_pass && xfer.xfer_count > 4'h1 &&
                 xfer.op inside {[5'h01:5'h0E]};
  assign lo_sw = {xfer.mem_data[7:0], xfer.mem_data[15:8],
                  xfer.mem_data[23:16], xfer.mem_data[31:24]};
  a_trace_lat: assert property (trace_valid |-> $past(xfer_valid))
    else $error("trace without transfer");
  a_addr_req: assert property (trace_valid |->
    trace.addr == $past(xfer.req_addr))
    else $error("traced address differs");
  a_size_map: assert property (trace_valid |->
    trace.size == $past(xfer.size))
    else $error("traced size differs");
  a_view_mem: assert property (trace_valid &&
    !$past(current_program_status_word_e) |->
    trace.data == $past(xfer.mem_data))
    else $error("data changed outside byte big mode");
  a_byte_raw: assert property (trace_valid &&
    trace.size == tdf_pkg::TDF_SZ_BYTE |->
    trace.data == $past(xfer.mem_data))
    else $error("byte data altered");
  a_dbl_order: assert property (trace_valid &&
    trace.size == tdf_pkg::TDF_SZ_DBL |->
    trace.data[31:0] == $past(xfer.mem_data[31:0]) ||
    trace.data[31:0] == $past(lo_sw))
    else $error("double word order wrong");
  a_big_cause: assert property (trace.byte_big && trace_valid |->
    $past(current_program_status_word_e))
    else $error("big flag without status bit");
  a_multi_cls: assert property (trace_valid |->
    trace.multi == $past(m_ok))
    else $error("multi flag wrong");
  c_multi: cover property (trace_valid && trace.multi);
  c_big: cover property (trace_valid && trace.byte_big);
  c_dbl: cover property (trace_valid && trace.size == tdf_pkg::TDF_SZ_DBL);
endmodule
bind tdf_formatter tdf_formatter_sva tdf_formatter_sva_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .xfer_valid(xfer_valid),
  .xfer(xfer), .trace_valid(trace_valid), .trace(trace),
  .current_program_status_word_e(current_program_status_word_e));
`default_nettype wire

// [tdf_core_model.sv]
// tdf_core_model: core load/store source feeding the formatter
// assumes: bench raises go for one cycle per transfer
`timescale 1ns/1ps
`default_nettype none
module tdf_core_model (
  // clock and request
  input  wire logic               ref_clk,
  input  wire logic               go,
  input  wire tdf_pkg::tdf_xfer_t req,
  input  wire logic               req_e,
  // core transfer
  output logic                    xfer_valid,
  output tdf_pkg::tdf_xfer_t      xfer,
  output logic                    e_bit
);
  // ----------------------------------------------------------
  // transfer shaping
  // ----------------------------------------------------------
  tdf_pkg::tdf_xfer_t x;
  always_comb begin
    x = req;
    x.word_big_ctrl = req.word_big_ctrl & ~req_e;
    // word-invariant byte access lands on the mirrored lane
    x.mem_addr = (x.word_big_ctrl && req.size == tdf_pkg::TDF_SZ_BYTE) ?
                 {req.req_addr[31:2], ~req.req_addr[1:0]} : req.req_addr;
  end
  always_ff @(posedge ref_clk) begin
    xfer_valid <= go;
    xfer       <= x;
    e_bit      <= req_e;
  end
endmodule
`default_nettype wire

// [trace_data_endian_view_formatter_tb.sv]
// trace_data_endian_view_formatter_tb: register and trace sequences
// assumes: tdf_core_model in front, checker bound separately
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  num_errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module trace_data_endian_view_formatter_tb;
  // ----------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------
  logic                ref_clk, reset_n, go, req_e, xfer_valid, e_bit;
  logic                trace_valid, awvalid, awready, wvalid, wready;
  logic                bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]          awaddr, araddr;
  logic [31:0]         wdata, rdata, d;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp, r;
  int                  num_errors, checks_done;
  tdf_pkg::tdf_xfer_t  req, xfer;
  tdf_pkg::tdf_trace_t trace;
  tdf_core_model tdf_core_model_i (.ref_clk(ref_clk), .go(go),
    .req(req), .req_e(req_e), .xfer_valid(xfer_valid), .xfer(xfer),
    .e_bit(e_bit));
  tdf_formatter tdf_formatter_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .xfer_valid(xfer_valid), .xfer(xfer), .trace_valid(trace_valid),
    .current_program_status_word_e(e_bit), .trace(trace),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge ref_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      r = bresp;
      @(posedge ref_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge ref_clk);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // loaded values arrive zero extended in the low lanes
  task automatic xf(input tdf_pkg::tdf_size_t s, input logic [63:0] v,
                    input logic e, wb, input int op, n, c);
    @(posedge ref_clk);
    req.size <= s;
    req.mem_data <= v;
    req_e <= e;
    req.word_big_ctrl <= wb;
    req.op <= tdf_pkg::tdf_op_t'(op);
    req.xfer_count <= 4'(n);
    req.cond_pass <= c[0];
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial begin
    {reset_n, go, req_e, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    req = '0;
    req.req_addr = 32'h0000_2000;
    req.unaligned_ctrl = 1'b1;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h00);
    `CHK(d, 32'h0000_0007)
    $display("reset test done");
    xf(tdf_pkg::TDF_SZ_WORD, 64'h1122_3344, 1, 0, 0, 1, 1);
    `CHK(trace_valid, 1'b1)
    `CHK(trace.data, 64'h4433_2211)
    `CHK(trace.byte_big, 1'b1)
    xf(tdf_pkg::TDF_SZ_HALF, 64'h1122, 1, 0, 0, 1, 1);
    `CHK(trace.data, 64'h2211)
    xf(tdf_pkg::TDF_SZ_DBL, 64'h5566_7788_1122_3344, 1, 0, 0, 1, 1);
    `CHK(trace.data, 64'h8877_6655_4433_2211)
    xf(tdf_pkg::TDF_SZ_BYTE, 64'hAB, 1, 0, 0, 1, 1);
    `CHK(trace.data, 64'hAB)
    xf(tdf_pkg::TDF_SZ_BYTE, 64'hCD, 0, 1, 0, 1, 1);
    `CHK(trace.addr, 32'h0000_2000)
    `CHK(trace.data, 64'hCD)
    xf(tdf_pkg::TDF_SZ_DBL, 64'h5566_7788_1122_3344, 0, 1, 0, 1, 1);
    `CHK(trace.data, 64'h5566_7788_1122_3344)
    `CHK(trace.data[63:32], 32'h5566_7788)
    wr(8'h00, 32'h0000_0006);
    xf(tdf_pkg::TDF_SZ_WORD, 64'h1122_3344, 1, 0, 0, 1, 1);
    `CHK(trace.data, 64'h1122_3344)
    wr(8'h00, 32'h0000_0005);
    xf(tdf_pkg::TDF_SZ_WORD, 64'h1122_3344, 1, 0, 0, 1, 1);
    `CHK(trace.byte_big, 1'b0)
    rd(8'h04);
    `CHK(d, 32'h0000_0001)
    $display("view test done");
    for (int i = 0; i < 16; i++) begin
      xf(tdf_pkg::TDF_SZ_WORD, 64'(i), 0, 0, i, 2, 1);
      `CHK(trace.multi, 1'(i >= 1 && i <= 14))
    end
    xf(tdf_pkg::TDF_SZ_WORD, 64'h1, 0, 0, 2, 1, 1);
    `CHK(trace.multi, 1'b0)
    xf(tdf_pkg::TDF_SZ_WORD, 64'h2, 0, 0, 2, 2, 0);
    `CHK(trace.multi, 1'b0)
    rd(8'h08);
    `CHK(d, 32'h0000_000E)
    xf(tdf_pkg::TDF_SZ_WORD, 64'h3, 0, 1, 2, 2, 1);
    `CHK(trace.multi, 1'b1)
    rd(8'h04);
    `CHK(d, 32'h0000_0003)
    $display("multi test done");
    wr(8'h00, 32'h0000_0003);
    xf(tdf_pkg::TDF_SZ_WORD, 64'h1, 0, 0, 0, 1, 1);
    `CHK(trace_valid, 1'b0)
    rd(8'h0C);
    `CHK(r, tdf_pkg::RESP_SLVERR)
    `CHK(d, 32'h0)
    wr(8'h04, 32'hFFFF_FFFF);
    `CHK(r, tdf_pkg::RESP_OKAY)
    wr(8'h0C, 32'h0000_0001);
    `CHK(r, tdf_pkg::RESP_SLVERR)
    rd(8'h00);
    `CHK(d, 32'h0000_0003)
    $display("bus test done");
    // reset in mid-run brings control and counter back
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h08);
    `CHK(d, 32'h0)
    rd(8'h00);
    `CHK(d, 32'h0000_0007)
    $display("second reset test done");
    stop_test();
  end
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
